// File: hdl/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush drops all content in one cycle.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_push;
  logic do_pop;
  logic [AW:0] level;

  // Full when pointers differ only in the wrap bit
  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = store[rd_ptr[AW-1:0]];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // Pointer update; flush beats both strobes
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end else begin
      if (do_push) next_wr_ptr = wr_ptr + 1'b1;
      if (do_pop) next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage carries no reset; only pointers define content
  always_ff @(posedge clk) begin
    if (do_push && !flush) store[wr_ptr[AW-1:0]] <= in_data;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_fifo_level: assert property (level <= (AW + 1)'(DEPTH)) // [RULE_09]
    else $error("fifo holds more than its depth");
  chk_fifo_stall: assert property ((level == (AW + 1)'(DEPTH)) |-> !in_ready) // [RULE_09]
    else $error("fifo accepts while full");
endmodule : byte_fifo

// File: hdl/eeprom_pkg.sv
// Shared constants and types for the two-wire serial memory slave.
// Assumes a single 100 MHz system clock; bus pins are sampled, not used as clocks.
package eeprom_pkg;
  // Array geometry
  localparam int MEM_BYTES = 512;
  localparam int ADDR_W = 9;
  localparam int BYTE_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;
  localparam int FIFO_DEPTH = 16;

  // Address byte layout
  localparam logic [3:0] TYPE_ID = 4'ha;
  localparam int POS_SEL_UPPER = 3;
  localparam int POS_SEL_LOWER = 2;
  localparam int POS_ADDR_MSB = 1;
  localparam int POS_DIR = 0;

  // Bit counter values of the last data bit and of the acknowledge slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Input synchroniser reset value: {inhibit, upper, lower, data, clock}
  localparam logic [4:0] SYNC_RST = 5'h03;

  // Self-timed write cycle, longest time rounds down
  localparam int CLK_HZ = 100_000_000;
  localparam int T_WR_MS = 5;
  localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_READ = 3'b100,
    ST_PROG = 3'b101
  } link_state_e;
endpackage : eeprom_pkg

// File: hdl/eeprom_slave.sv
// Two-wire serial slave with a 512-byte array, page writes and reads.
// Assumes bus pins arrive asynchronously and the bus clock is far below clk.
//
// Overview of operation
// [RULE_01] Array of 512 bytes, each addressable over the serial link.
// [RULE_02] Up to four parts share a bus, each at its own address.
// [RULE_03] Two select inputs must equal address bits three and two.
// [RULE_04] Sample data on clock rise, change driven data on clock fall.
// [RULE_05] Write inhibit high blocks every array write; code only refuses new bytes, already queued bytes are still written.
// [RULE_06] Undriven select and inhibit inputs count as zero; code has no pull-downs and relies on pulls outside the part.
// [RULE_07] Data line is only pulled low or released, never driven high.
// [RULE_08] Master keeps the clock line high while the bus idles.
// [RULE_09] Page writes of up to 16 bytes, shorter writes allowed.
// [RULE_10] Internal programming cycle finishes within 5 ms.
// [RULE_11] Random reads and sequential reads with an incrementing pointer.
// [RULE_12] Works at 100 kHz, 400 kHz and 1 MHz bus clocks.
// [RULE_13] Address byte must carry 1010 in its upper four bits.
// [RULE_14] Bytes travel MSB first, acknowledged on a ninth clock.
// [RULE_15] Data fall with clock high is start, data rise is stop.
// [RULE_16] Array is 32 pages of 16 bytes; page writes wrap in page.
// [RULE_17] Address byte bit zero selects read when one, write when zero.
// [RULE_18] Address byte bit one carries the memory address MSB.
`timescale 1ns/10ps
module eeprom_slave #(
  parameter int WRITE_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic hw_select_lower,
  input wire logic hw_select_upper,
  input wire logic write_inhibit
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int AW = eeprom_pkg::ADDR_W;
  localparam int BW = eeprom_pkg::BYTE_W;

  // Two-stage synchronisers plus an edge stage for clock and data
  logic [4:0] pins_meta;
  logic [4:0] pins_sync;
  logic [1:0] edge_last;
  logic scl_s;
  logic sda_s;
  logic sel_lower_s;
  logic sel_upper_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Undriven select and inhibit pins are pulled low outside, so their reset to zero is safe; clock and data reset high [RULE_06]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_meta <= eeprom_pkg::SYNC_RST;
      pins_sync <= eeprom_pkg::SYNC_RST;
      edge_last <= eeprom_pkg::SYNC_RST[1:0];
    end else begin
      pins_meta <= {write_inhibit, hw_select_upper, hw_select_lower, sda_in, scl};
      pins_sync <= pins_meta;
      edge_last <= pins_sync[1:0];
    end
  end

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign sel_lower_s = pins_sync[2];
  assign sel_upper_s = pins_sync[3];
  assign wp_s = pins_sync[4];

  // Edges seen on the sampled clock; fine for bus rates up to 1 MHz [RULE_12]
  assign scl_rise = scl_s && !edge_last[0];
  assign scl_fall = !scl_s && edge_last[0];
  // Data moving while the clock stays high marks start or stop [RULE_15]
  assign start_det = scl_s && edge_last[0] && !sda_s && edge_last[1];
  assign stop_det = scl_s && edge_last[0] && sda_s && !edge_last[1];

  // Protocol and write engine state
  eeprom_pkg::link_state_e state;
  eeprom_pkg::link_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [BW-1:0] rx;
  logic [BW-1:0] next_rx;
  logic [BW-1:0] tx;
  logic [BW-1:0] next_tx;
  logic [AW-1:0] ptr;
  logic [AW-1:0] next_ptr;
  logic [AW-1:0] prog_addr;
  logic [AW-1:0] next_prog_addr;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic ack;
  logic next_ack;
  logic next_oe;

  // Array, data path FIFO and handshakes
  logic [BW-1:0] mem [eeprom_pkg::MEM_BYTES];
  logic [BW-1:0] rx_byte;
  logic [BW-1:0] fifo_data;
  logic push;
  logic push_ready;
  logic flush;
  logic drain_valid;
  logic drain;
  logic addr_match;

  // Byte completed on the eighth rise, MSB first [RULE_14]
  assign rx_byte = {rx[BW-2:0], sda_s};
  // Type code and both select pins must agree [RULE_02] [RULE_03] [RULE_13]
  assign addr_match = (rx_byte[7:4] == eeprom_pkg::TYPE_ID)
                   && (rx_byte[eeprom_pkg::POS_SEL_UPPER] == sel_upper_s)
                   && (rx_byte[eeprom_pkg::POS_SEL_LOWER] == sel_lower_s);
  // FIFO drains only during the internal cycle, so it really fills
  assign drain = (state == eeprom_pkg::ST_PROG) && drain_valid;

  byte_fifo #(
    .WIDTH(BW),
    .DEPTH(eeprom_pkg::FIFO_DEPTH)
  ) u_page_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(rx_byte),
    .out_valid(drain_valid),
    .out_ready(drain),
    .out_data(fifo_data)
  );

  // Next-state logic for the whole link engine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rx = rx;
    next_tx = tx;
    next_ptr = ptr;
    next_prog_addr = prog_addr;
    next_timer = timer;
    next_ack = ack;
    next_oe = sda_oe;
    push = 1'b0;
    flush = 1'b0;
    if (state == eeprom_pkg::ST_PROG) begin
      // Busy: bus ignored, so polling masters see no acknowledge
      next_timer = TW'(timer + 1'b1);
      if (drain_valid) begin
        // Low nibble wraps so a page write stays inside its page [RULE_16]
        next_prog_addr = {prog_addr[AW-1:eeprom_pkg::PAGE_W],
                          prog_addr[eeprom_pkg::PAGE_W-1:0] + 4'h1};
      end else if (timer >= TW'(WRITE_CYCLES - 1)) begin
        next_state = eeprom_pkg::ST_IDLE; // [RULE_10]
        next_ptr = prog_addr;
        next_timer = '0;
      end
    end else if (start_det) begin
      // Repeated start also drops a half-built page [RULE_15]
      next_state = eeprom_pkg::ST_ADDR;
      next_cnt = '0;
      next_oe = 1'b0;
      flush = 1'b1;
    end else if (stop_det) begin
      next_oe = 1'b0;
      next_cnt = '0;
      next_timer = '0;
      if (state == eeprom_pkg::ST_WDATA && drain_valid) begin
        next_state = eeprom_pkg::ST_PROG; // [RULE_09]
      end else begin
        next_state = eeprom_pkg::ST_IDLE;
      end
    end else if (scl_rise && state != eeprom_pkg::ST_IDLE) begin
      if (cnt == eeprom_pkg::BIT_ACK) begin
        // Ninth rise: master answer in read, move on in write [RULE_14]
        next_cnt = '0;
        if (state == eeprom_pkg::ST_READ) begin
          if (sda_s) begin
            next_state = eeprom_pkg::ST_IDLE;
          end else begin
            next_tx = mem[ptr]; // [RULE_11]
            next_ptr = ptr + 9'h001;
          end
        end else if (ack) begin
          case (state)
            eeprom_pkg::ST_ADDR: begin
              if (rx[eeprom_pkg::POS_DIR]) begin
                next_state = eeprom_pkg::ST_READ; // [RULE_17]
                next_tx = mem[ptr]; // [RULE_11]
                next_ptr = ptr + 9'h001;
              end else begin
                next_state = eeprom_pkg::ST_WADDR;
              end
            end
            eeprom_pkg::ST_WADDR: next_state = eeprom_pkg::ST_WDATA;
            default: next_state = state;
          endcase
        end
      end else begin
        // Capture on rising edges only [RULE_04]
        next_rx = rx_byte;
        next_cnt = cnt + 4'h1;
        if (cnt == eeprom_pkg::BIT_LAST) begin
          case (state)
            eeprom_pkg::ST_ADDR: begin
              next_ack = addr_match;
              if (addr_match) begin
                next_ptr[AW-1] = rx_byte[eeprom_pkg::POS_ADDR_MSB]; // [RULE_18]
              end else begin
                next_state = eeprom_pkg::ST_IDLE;
              end
            end
            eeprom_pkg::ST_WADDR: begin
              next_ack = 1'b1;
              next_ptr = {ptr[AW-1], rx_byte}; // [RULE_01]
              next_prog_addr = {ptr[AW-1], rx_byte};
            end
            eeprom_pkg::ST_WDATA: begin
              // Inhibited or full page: byte refused and left unacknowledged
              next_ack = !wp_s && push_ready; // [RULE_05] [RULE_09]
              push = !wp_s && push_ready; // [RULE_05]
            end
            default: next_ack = 1'b0;
          endcase
        end
      end
    end else if (scl_fall && state != eeprom_pkg::ST_IDLE) begin
      // Driven data only moves after a falling edge [RULE_04]
      if (state == eeprom_pkg::ST_READ) begin
        if (cnt == eeprom_pkg::BIT_ACK) begin
          next_oe = 1'b0;
        end else begin
          next_oe = !tx[3'(eeprom_pkg::BIT_LAST - cnt)]; // [RULE_14]
        end
      end else begin
        next_oe = (cnt == eeprom_pkg::BIT_ACK) && ack; // [RULE_14]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= eeprom_pkg::ST_IDLE;
      cnt <= '0;
      rx <= '0;
      tx <= '0;
      ptr <= '0;
      prog_addr <= '0;
      timer <= '0;
      ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rx <= next_rx;
      tx <= next_tx;
      ptr <= next_ptr;
      prog_addr <= next_prog_addr;
      timer <= next_timer;
      ack <= next_ack;
      sda_oe <= next_oe;
      sda_out <= 1'b0; // Open drain: the pin level is only ever low [RULE_07]
    end
  end

  // Array write from the page buffer; no reset, contents are nonvolatile
  always_ff @(posedge clk) begin
    if (drain) mem[prog_addr] <= fifo_data; // [RULE_01] [RULE_16]
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_oe_after_fall: assert property ($rose(sda_oe) |-> $past(scl_fall)) // [RULE_04]
    else $error("data pulled low without a clock fall");
  chk_ack_slot: assert property ( // [RULE_14]
    ($rose(sda_oe) && state != eeprom_pkg::ST_READ) |-> (cnt == eeprom_pkg::BIT_ACK))
    else $error("acknowledge outside the ninth clock");
  chk_open_drain: assert property (sda_out == 1'b0) // [RULE_07]
    else $error("data line driven high");
  chk_inhibit_block: assert property ((push || drain_valid) |-> !$past(wp_s)) // [RULE_05]
    else $error("byte queued while writes inhibited");
  chk_type_id: assert property ( // [RULE_13]
    ($rose(sda_oe) && state == eeprom_pkg::ST_ADDR) |-> (rx[7:4] == eeprom_pkg::TYPE_ID))
    else $error("acknowledged a foreign type code");
  chk_select_match: assert property ( // [RULE_03]
    ($rose(sda_oe) && state == eeprom_pkg::ST_ADDR)
    |-> (rx[eeprom_pkg::POS_SEL_UPPER] == sel_upper_s
         && rx[eeprom_pkg::POS_SEL_LOWER] == sel_lower_s))
    else $error("acknowledged another select address");
  chk_write_bound: assert property ( // [RULE_10]
    (state == eeprom_pkg::ST_PROG) |-> (timer < TW'(WRITE_CYCLES)))
    else $error("internal write runs past its limit");
  chk_page_wrap: assert property ( // [RULE_16]
    (state == eeprom_pkg::ST_PROG && $past(state) == eeprom_pkg::ST_PROG)
    |-> (prog_addr[AW-1:eeprom_pkg::PAGE_W] == $past(prog_addr[AW-1:eeprom_pkg::PAGE_W])))
    else $error("page write left its page");
  chk_seq_step: assert property ( // [RULE_11]
    (state == eeprom_pkg::ST_READ && scl_rise && cnt == eeprom_pkg::BIT_ACK && !sda_s
     && !start_det && !stop_det) |=> (ptr == $past(ptr) + 9'h001))
    else $error("sequential read pointer did not step");
endmodule : eeprom_slave

// File: testbench/bus_master.sv
// Two-wire bus master model: drives the serial clock and pulls data low.
// Assumes a pull-up on the data wire; moves its lines only on falling clk.
`timescale 1ns/10ps
module bus_master #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Half of the 80 ns bus clock; slave sync delay leaves one clk of margin
  task automatic half_bit();
    repeat (HALF) @(negedge clk);
  endtask : half_bit

  // Start or repeated start: data falls while clock stays high
  task automatic start();
    sda_pull = 1'b0;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_pull = 1'b1;
    half_bit();
    scl = 1'b0;
  endtask : start

  // Stop: data rises while clock stays high, then bus idles
  task automatic stop();
    @(negedge clk);
    sda_pull = 1'b1;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_pull = 1'b0;
    half_bit();
  endtask : stop

  // One bit per 80 ns: data set 1 clk into low phase, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    @(negedge clk);
    sda_pull = ~b;
    repeat (HALF - 1) @(negedge clk);
    scl = 1'b1;
    half_bit();
    r = sda_wire;
    scl = 1'b0;
  endtask : bit_io

  // Byte out MSB first, ninth clock returns the acknowledge level
  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nack);
  endtask : wbyte

  // Byte in MSB first; master acks unless it is the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rbyte
endmodule : bus_master

// File: testbench/tb_serial_eeprom_two_wire_slave.sv
// Self-checking bench for the two-wire memory slave with a master model.
// Assumes a short write cycle parameter; pins are driven on falling clk.
`timescale 1ns/10ps
module tb_serial_eeprom_two_wire_slave;
  localparam int WC = 200;
  logic clk, sys_rst, scl, sda_pull, sda_out, sda_oe, sda_wire;
  logic hw_select_lower, hw_select_upper, write_inhibit;
  logic [7:0] mirror [512];
  int errors, checks, cycles;

  // Wired-AND data line with pull-up
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

  eeprom_slave #(.WRITE_CYCLES(WC)) dut_u (.clk(clk), .sys_rst(sys_rst), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .hw_select_lower(hw_select_lower),
    .hw_select_upper(hw_select_upper), .write_inhibit(write_inhibit));
  bus_master master_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Device may only pull low while enabled, and hangs are cut short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, sda_out, 1'b0);
    end
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Address byte: type, selects, memory MSB, direction
  function automatic logic [7:0] abyte(input logic [1:0] s, input logic m, input logic rd);
    return {4'ha, s, m, rd};
  endfunction : abyte

  // Start plus address byte, acknowledge compared with expectation
  task automatic addr(input logic [1:0] s, input logic m, input logic rd, input logic en);
    logic n;
    master_u.start();
    master_u.wbyte(abyte(s, m, rd), n);
    check({7'h0, n}, {7'h0, en});
  endtask : addr

  // Page write of n bytes; a busy probe follows when anything was taken
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
    logic ack_n, took;
    logic [8:0] p;
    took = 1'b0;
    addr(2'h2, a[8], 1'b0, 1'b0);
    master_u.wbyte(a[7:0], ack_n);
    check({7'h0, ack_n}, 8'h00);
    for (int i = 0; i < n; i++) begin
      p = {a[8:4], a[3:0] + 4'(i)};
      master_u.wbyte(d0 + 8'(i), ack_n);
      check({7'h0, ack_n}, {7'h0, (i >= 16) | write_inhibit});
      if (i < 16 && !write_inhibit) begin
        mirror[p] = d0 + 8'(i);
        took = 1'b1;
      end
    end
    master_u.stop();
    if (took) begin
      addr(2'h2, 1'b0, 1'b0, 1'b1);
      master_u.stop();
    end
    repeat (WC + 20) @(negedge clk);
  endtask : wr

  // Random read then sequential bytes, compared with the mirror
  task automatic rd(input logic [8:0] a, input int n);
    logic ack_n;
    logic [7:0] d;
    addr(2'h2, a[8], 1'b0, 1'b0);
    master_u.wbyte(a[7:0], ack_n);
    check({7'h0, ack_n}, 8'h00);
    addr(2'h2, a[8], 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      master_u.rbyte(i == n - 1, d);
      check(d, mirror[9'(a + 9'(i))]);
    end
    master_u.stop();
  endtask : rd

  // Only the matching select pair and type pattern are acknowledged
  task automatic t_select();
    logic n;
    // Write direction: a read would leave the part driving data into the stop
    for (int s = 0; s < 4; s++) begin
      addr(2'(s), 1'b0, 1'b0, s != 2);
      master_u.stop();
    end
    master_u.start();
    master_u.wbyte(8'hb4, n);
    check({7'h0, n}, 8'h01);
    master_u.stop();
  endtask : t_select

  // Partial page crossing the page end wraps inside the page
  task automatic t_page();
    wr(9'h1fd, 4, 8'h10);
    wr(9'h000, 1, 8'h77);
    rd(9'h1fd, 3);
    rd(9'h1f0, 1);
    rd(9'h1ff, 2);
  endtask : t_page

  // Seventeenth byte of a page is refused
  task automatic t_full();
    wr(9'h020, 17, 8'h40);
    rd(9'h020, 16);
  endtask : t_full

  // Inhibit refuses data, array keeps the old byte
  task automatic t_inhibit();
    @(negedge clk);
    write_inhibit = 1'b1;
    wr(9'h1fd, 1, 8'haa);
    @(negedge clk);
    write_inhibit = 1'b0;
    rd(9'h1fd, 1);
  endtask : t_inhibit

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Reset for 6 cycles with the bus idle, then the scenarios
  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    sys_rst = 1'b1;
    hw_select_upper = 1'b1;
    hw_select_lower = 1'b0;
    write_inhibit = 1'b0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    t_select();
    t_page();
    t_full();
    t_inhibit();
    give_verdict();
  end
endmodule : tb_serial_eeprom_two_wire_slave
